// >>> src/dsu_pkg.sv
/*
  Package for the debug support unit: register address, field positions,
  reset value, trace modes and the carrier structs of the block.
  Assumes a 32-bit word register reached on the private peripheral bus.
*/
package dsu_pkg;
  localparam logic [31:0] DSU_CFG_ADDR = 32'he0042004;
  localparam logic [31:0] DSU_CFG_RESET = 32'h00000000;
  localparam logic [31:0] DSU_CFG_WMASK = 32'h0fddbfe7;
  localparam int DSU_SLEEP_BIT = 0;
  localparam int DSU_STOP_BIT = 1;
  localparam int DSU_STANDBY_BIT = 2;
  localparam int DSU_TRACE_EN_BIT = 5;
  localparam int DSU_TRACE_MODE_LSB = 6;
  localparam int DSU_IDOG_BIT = 8;
  localparam int DSU_WDOG_BIT = 9;
  localparam int DSU_TIM_LO_LSB = 10;
  localparam int DSU_I2C1_BIT = 15;
  localparam int DSU_I2C2_BIT = 16;
  localparam int DSU_TIM_BASIC_LSB = 18;
  localparam int DSU_TIM_HI_LSB = 22;
  localparam int DSU_TIM_TOP_LSB = 25;
  localparam int DSU_TRACE_CLK_DELAY = 2;

  typedef enum logic [1:0] {
    DSU_TRACE_ASYNC,
    DSU_TRACE_SYNC1,
    DSU_TRACE_SYNC2,
    DSU_TRACE_SYNC4
  } dsu_trace_mode_e;

  typedef enum logic [1:0] {
    DSU_SRC_OFF,
    DSU_SRC_SYSCLK,
    DSU_SRC_RC
  } dsu_clk_src_e;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } dsu_bus_req_s;

  typedef struct packed {
    logic core_clk_on;
    logic bus_clk_on;
    dsu_clk_src_e src;
    logic rc_osc_keep;
    logic digital_power_on;
    logic sys_reset_req;
    logic clk_cfg_to_reset;
  } dsu_lp_ctl_s;
endpackage

// >>> src/dsu_lowpower_ctl.sv
/*
  Low-power clock and power steering of the debug support unit.
  Assumes the power controller gives one-hot style mode levels.
*/
`timescale 1ns/1ps
`default_nettype none
module dsu_lowpower_ctl
  import dsu_pkg::*;
(
  input wire logic sleep_in,
  input wire logic stop_in,
  input wire logic standby_in,
  input wire logic sleep_keep_in,
  input wire logic stop_keep_in,
  input wire logic standby_keep_in,
  output dsu_lp_ctl_s ctl_out
);
  always_comb begin
    ctl_out = '{core_clk_on: 1'b1, bus_clk_on: 1'b1, src: DSU_SRC_SYSCLK,
                rc_osc_keep: 1'b0, digital_power_on: 1'b1,
                sys_reset_req: 1'b0, clk_cfg_to_reset: 1'b0};
    if (standby_in) begin
      // Kept power means the debugger link survives, but a reset is still
      // issued so software sees the same exit path either way.
      ctl_out.core_clk_on = standby_keep_in; // [RQ5] [RQ6]
      ctl_out.bus_clk_on = standby_keep_in; // [RQ5] [RQ6]
      ctl_out.src = standby_keep_in ? DSU_SRC_RC : DSU_SRC_OFF; // [RQ6]
      ctl_out.rc_osc_keep = standby_keep_in; // [RQ6]
      ctl_out.digital_power_on = standby_keep_in; // [RQ5]
      ctl_out.sys_reset_req = 1'b1; // [RQ6]
      ctl_out.clk_cfg_to_reset = 1'b1; // [RQ5]
    end else if (stop_in) begin
      ctl_out.core_clk_on = stop_keep_in; // [RQ3] [RQ4]
      ctl_out.bus_clk_on = stop_keep_in; // [RQ3] [RQ4]
      ctl_out.src = stop_keep_in ? DSU_SRC_RC : DSU_SRC_OFF; // [RQ4]
      ctl_out.rc_osc_keep = stop_keep_in; // [RQ4]
      ctl_out.clk_cfg_to_reset = 1'b1; // [RQ3] [RQ4]
    end else if (sleep_in) begin
      ctl_out.bus_clk_on = sleep_keep_in; // [RQ1] [RQ2]
    end
  end
endmodule
`default_nettype wire

// >>> src/dsu_trace_clk.sv
/*
  Trace port input clock enable: low until the trace enable has been
  seen set for a fixed number of cycles. Assumes one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dsu_trace_clk
  import dsu_pkg::*;
#(
  parameter int DELAY = DSU_TRACE_CLK_DELAY
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic trace_en_in,
  output logic trace_clk_en_out
);
  logic [DELAY-1:0] shift_reg;
  logic [DELAY-1:0] shift_next;

  assign shift_next = {shift_reg[DELAY-2:0], trace_en_in};
  assign trace_clk_en_out = shift_reg[DELAY-1];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= trace_en_in ? shift_next : '0; // [RQ20]
    end
  end

  AST_TRACE_CLK_DELAY: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    $rose(trace_en_in) ##1 trace_en_in |=> trace_clk_en_out)
    else $error("trace clock late"); // [RQ20]
endmodule
`default_nettype wire

// >>> src/dsu_config.sv
/*
  Debug support unit configuration register and its decode.
  Holds the debug_mcu_config register, steers low-power clocking,
  peripheral freezes under core halt and trace pin assignment.
  Assumes a simple synchronous private peripheral bus request with a
  combinational read, a power-on reset separate from system reset, and
  a core-halted level from the debug logic.
*/
// Overview of operation
// [RQ1] Sleep keep bit feeds bus clock too
// [RQ2] Plain sleep gates bus clock only
// [RQ3] Plain stop kills clocks, reset config
// [RQ4] Stop keep runs cores from RC
// [RQ5] Plain standby unpowers digital section
// [RQ6] Standby keep powers, RC, system reset
// [RQ7] Trace disabled assigns no pins
// [RQ8] Trace mode picks async or sync width
// [RQ9] Timer freeze bits stop counters on halt
// [RQ10] Basic timers freeze also disable outputs
// [RQ11] Complementary timers force outputs off
// [RQ12] SMBus timeout freezes on halt
// [RQ13] Window watchdog freezes on halt
// [RQ14] Independent watchdog freezes on halt
// [RQ15] Only power-on reset clears register
// [RQ16] Accessor uses 32-bit accesses only
// [RQ17] Writers keep reserved bits zero
// [RQ18] Register sits at fixed bus address
// [RQ19] Core software may also write
// [RQ20] Trace clock starts two cycles late
// [RQ21] Freeze equals bit AND core halted
`timescale 1ns/1ps
`default_nettype none
module dsu_config
  import dsu_pkg::*;
#(
  parameter int N_TIM_LO = 4,
  parameter int N_TIM_BASIC = 3,
  parameter int N_TIM_HI = 3,
  parameter int N_TIM_TOP = 3
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic por_b_in,
  input wire logic sys_rst_b_in,
  input wire dsu_bus_req_s dbg_req_in,
  input wire dsu_bus_req_s cpu_req_in,
  output logic [31:0] rdata_out,
  output logic ready_out,
  output logic error_out,
  input wire logic core_halted_in,
  input wire logic sleep_in,
  input wire logic stop_in,
  input wire logic standby_in,
  output dsu_lp_ctl_s lp_ctl_out,
  output logic [N_TIM_LO-1:0] tim_lo_freeze_out,
  output logic [N_TIM_BASIC-1:0] tim_basic_freeze_out,
  output logic [N_TIM_BASIC-1:0] tim_basic_out_dis_out,
  output logic [N_TIM_HI-1:0] tim_hi_freeze_out,
  output logic [N_TIM_TOP-1:0] tim_top_freeze_out,
  output logic [N_TIM_LO-1:0] tim_lo_moe_force_off_out,
  output logic window_dog_freeze_out,
  output logic indep_dog_freeze_out,
  output logic i2c_one_timeout_freeze_out,
  output logic i2c_two_timeout_freeze_out,
  output logic trace_swo_assign_out,
  output logic trace_clk_assign_out,
  output logic [3:0] trace_data_assign_out,
  output logic trace_clk_en_out
);
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic dbg_hit;
  logic cpu_hit;
  logic wr_en;
  logic [31:0] wr_data;
  logic trace_en;
  dsu_trace_mode_e trace_mode;
  logic halted;

  function automatic logic addr_hit(input dsu_bus_req_s r);
    return r.sel && (r.addr == DSU_CFG_ADDR);
  endfunction

  function automatic logic full_word(input dsu_bus_req_s r);
    return r.be == 4'hf;
  endfunction

  // The debugger wins a same-cycle collision; the core write is dropped.
  assign dbg_hit = addr_hit(dbg_req_in); // [RQ18]
  assign cpu_hit = addr_hit(cpu_req_in); // [RQ18] [RQ19]
  assign wr_en = (dbg_hit && dbg_req_in.wr && full_word(dbg_req_in)) ||
                 (cpu_hit && cpu_req_in.wr && full_word(cpu_req_in)); // [RQ16]
  assign wr_data = (dbg_hit && dbg_req_in.wr) ? dbg_req_in.wdata
                                              : cpu_req_in.wdata;
  // Reserved positions are never stored, so they always read zero.
  assign cfg_next = wr_en ? (wr_data & DSU_CFG_WMASK) : cfg_reg; // [RQ17]

  assign ready_out = dbg_req_in.sel || cpu_req_in.sel;
  assign error_out = (dbg_req_in.sel && !dbg_hit) ||
                     (cpu_req_in.sel && !cpu_hit) ||
                     (dbg_hit && !full_word(dbg_req_in)) ||
                     (cpu_hit && !full_word(cpu_req_in)); // [RQ16]
  assign rdata_out = (dbg_hit || cpu_hit) ? cfg_reg : 32'h00000000;

  // Only power-on reset clears the register; system reset is ignored
  // here so that the debugger can set it up while the core is held.
  always_ff @(posedge clk_sys_in or negedge por_b_in) begin
    if (!por_b_in) begin
      cfg_reg <= DSU_CFG_RESET; // [RQ15]
    end else begin
      cfg_reg <= cfg_next; // [RQ15] [RQ19]
    end
  end

  assign halted = core_halted_in;
  assign tim_lo_freeze_out =
    cfg_reg[DSU_TIM_LO_LSB +: N_TIM_LO] & {N_TIM_LO{halted}}; // [RQ9] [RQ21]
  assign tim_basic_freeze_out =
    cfg_reg[DSU_TIM_BASIC_LSB +: N_TIM_BASIC] &
    {N_TIM_BASIC{halted}}; // [RQ9] [RQ21]
  assign tim_basic_out_dis_out = tim_basic_freeze_out; // [RQ10]
  assign tim_hi_freeze_out =
    cfg_reg[DSU_TIM_HI_LSB +: N_TIM_HI] & {N_TIM_HI{halted}}; // [RQ9]
  assign tim_top_freeze_out =
    cfg_reg[DSU_TIM_TOP_LSB +: N_TIM_TOP] & {N_TIM_TOP{halted}}; // [RQ9]
  // Frozen complementary-output timers must not leave drives on.
  assign tim_lo_moe_force_off_out = tim_lo_freeze_out; // [RQ11]
  assign window_dog_freeze_out = cfg_reg[DSU_WDOG_BIT] & halted; // [RQ13]
  assign indep_dog_freeze_out = cfg_reg[DSU_IDOG_BIT] & halted; // [RQ14]
  assign i2c_one_timeout_freeze_out = cfg_reg[DSU_I2C1_BIT] & halted; // [RQ12]
  assign i2c_two_timeout_freeze_out = cfg_reg[DSU_I2C2_BIT] & halted; // [RQ12]

  assign trace_en = cfg_reg[DSU_TRACE_EN_BIT];
  assign trace_mode = dsu_trace_mode_e'(cfg_reg[DSU_TRACE_MODE_LSB +: 2]);
  always_comb begin
    trace_swo_assign_out = 1'b0;
    trace_clk_assign_out = 1'b0;
    trace_data_assign_out = 4'h0;
    if (trace_en) begin // [RQ7]
      case (trace_mode)
        DSU_TRACE_ASYNC: begin
          trace_swo_assign_out = 1'b1; // [RQ8]
        end
        DSU_TRACE_SYNC1: begin
          trace_clk_assign_out = 1'b1;
          trace_data_assign_out = 4'h1; // [RQ8]
        end
        DSU_TRACE_SYNC2: begin
          trace_clk_assign_out = 1'b1;
          trace_data_assign_out = 4'h3; // [RQ8]
        end
        DSU_TRACE_SYNC4: begin
          trace_clk_assign_out = 1'b1;
          trace_data_assign_out = 4'hf; // [RQ8]
        end
        default: begin
          trace_data_assign_out = 4'h0;
        end
      endcase
    end
  end

  dsu_trace_clk #(
    .DELAY(DSU_TRACE_CLK_DELAY)
  ) u_trace_clk (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(por_b_in),
    .trace_en_in(trace_en),
    .trace_clk_en_out(trace_clk_en_out)
  );

  dsu_lowpower_ctl u_lp (
    .sleep_in(sleep_in),
    .stop_in(stop_in),
    .standby_in(standby_in),
    .sleep_keep_in(cfg_reg[DSU_SLEEP_BIT]),
    .stop_keep_in(cfg_reg[DSU_STOP_BIT]),
    .standby_keep_in(cfg_reg[DSU_STANDBY_BIT]),
    .ctl_out(lp_ctl_out)
  );

  sequence s_dbg_write;
    dbg_hit && dbg_req_in.wr && full_word(dbg_req_in);
  endsequence

  AST_WRITE_UNDER_SYSRST: assert property (@(posedge clk_sys_in)
    disable iff (!por_b_in)
    (s_dbg_write and !sys_rst_b_in) |=>
    cfg_reg == ($past(dbg_req_in.wdata) & DSU_CFG_WMASK))
    else $error("debugger write lost"); // [RQ15]
  AST_HOLD_NO_WRITE: assert property (@(posedge clk_sys_in)
    disable iff (!por_b_in)
    !wr_en |=> $stable(cfg_reg))
    else $error("config changed without write"); // [RQ15]
  AST_CPU_WRITE: assert property (@(posedge clk_sys_in)
    disable iff (!por_b_in)
    (cpu_hit && cpu_req_in.wr && full_word(cpu_req_in) && !dbg_req_in.sel)
    |=> cfg_reg == ($past(cpu_req_in.wdata) & DSU_CFG_WMASK))
    else $error("core write lost"); // [RQ19]
  AST_NARROW_IGNORED: assert property (@(posedge clk_sys_in)
    disable iff (!por_b_in)
    (cpu_hit && !full_word(cpu_req_in) && !dbg_req_in.sel) |->
    error_out ##1 $stable(cfg_reg))
    else $error("narrow access accepted"); // [RQ16]
  AST_RESERVED_ZERO: assert property (@(posedge clk_sys_in)
    (cfg_reg & ~DSU_CFG_WMASK) == 32'h00000000)
    else $error("reserved bit set"); // [RQ17]
  AST_NO_TRACE: assert property (@(posedge clk_sys_in)
    !trace_en |-> (!trace_swo_assign_out && !trace_clk_assign_out &&
    trace_data_assign_out == 4'h0) ##2 !trace_clk_en_out)
    else $error("trace pins assigned while off"); // [RQ7]
  AST_SLEEP_BUS: assert property (@(posedge clk_sys_in)
    (sleep_in && !stop_in && !standby_in) |->
    (lp_ctl_out.bus_clk_on == cfg_reg[DSU_SLEEP_BIT] &&
     lp_ctl_out.core_clk_on && !lp_ctl_out.clk_cfg_to_reset))
    else $error("sleep bus clock wrong"); // [RQ1]
  AST_SYNC4: assert property (@(posedge clk_sys_in)
    (trace_en && trace_mode == DSU_TRACE_SYNC4) |->
    trace_clk_assign_out && trace_data_assign_out == 4'hf)
    else $error("sync4 pins wrong"); // [RQ8]
  AST_WDOG_FREEZE: assert property (@(posedge clk_sys_in)
    window_dog_freeze_out == (cfg_reg[DSU_WDOG_BIT] && core_halted_in))
    else $error("window watchdog freeze wrong"); // [RQ13]
  AST_IDOG_FREEZE: assert property (@(posedge clk_sys_in)
    indep_dog_freeze_out == (cfg_reg[DSU_IDOG_BIT] && core_halted_in))
    else $error("independent watchdog freeze wrong"); // [RQ14]
  AST_TIM_FREEZE: assert property (@(posedge clk_sys_in)
    !core_halted_in |-> tim_lo_freeze_out == '0 &&
    tim_basic_freeze_out == '0 && !i2c_one_timeout_freeze_out)
    else $error("freeze without halt"); // [RQ21]
  AST_MOE_OFF: assert property (@(posedge clk_sys_in)
    tim_lo_moe_force_off_out == tim_lo_freeze_out &&
    tim_basic_out_dis_out == tim_basic_freeze_out)
    else $error("outputs not disabled while frozen"); // [RQ11]
  AST_STOP_CLK: assert property (@(posedge clk_sys_in)
    (stop_in && !standby_in) |->
    lp_ctl_out.core_clk_on == cfg_reg[DSU_STOP_BIT])
    else $error("stop clock wrong"); // [RQ3]
endmodule
`default_nettype wire

// >>> tb/dsu_bus_host.sv
/*
  Bus requester model for the debug support unit register port, used
  for both the debugger and core software.
  Assumes a zero-wait target: ready, error and read data are valid in
  the cycle of the request.
*/
`timescale 1ns/1ps
`default_nettype none
module dsu_bus_host
  import dsu_pkg::*;
(
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic error_in,
  input wire logic [31:0] rdata_in,
  output var dsu_bus_req_s req_out
);
  initial begin
    req_out = '0;
  end

  // Called just after an edge; returns just after an edge, bus idle.
  task automatic access(input logic wr, input logic [31:0] addr,
      input logic [31:0] wdata, input logic [3:0] be, input logic raw,
      output logic [31:0] rdata, output logic rdy, output logic err);
    req_out.sel = 1'b1;
    req_out.wr = wr;
    req_out.addr = addr;
    req_out.wdata = raw ? wdata : (wdata & DSU_CFG_WMASK);
    req_out.be = raw ? be : 4'hf;
    @(posedge clk_in);
    rdata = rdata_in;
    rdy = ready_in;
    err = error_in;
    #1;
    // Released lines flip so that a stale value cannot pass for a hold.
    req_out.sel = 1'b0;
    req_out.addr = ~req_out.addr;
    req_out.wdata = ~req_out.wdata;
    @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_dsu_config.sv
/*
  Self-checking bench for dsu_config: access from debugger and core,
  freezes, trace pins, low-power steering and power-on-only reset.
  Assumes dsu_bus_host models each requester on the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dsu_config;
  import dsu_pkg::*;
  logic clk_sys_in, rst_b_in, por_b_in, sys_rst_b_in, core_halted_in;
  logic sleep_in, stop_in, standby_in;
  dsu_bus_req_s dbg_req, cpu_req;
  dsu_lp_ctl_s lp;
  logic [31:0] rdata, rd, d;
  logic ready, error, swo, tclk, tclk_en, wd, id, i1, i2, rdy, er;
  logic [3:0] lo, lo_moe, tdata;
  logic [2:0] bas, bas_dis, hi, top;
  int miscompares = 0;
  int n_checks = 0;
  integer seed = 32'h6810;

  dsu_config i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .por_b_in(por_b_in), .sys_rst_b_in(sys_rst_b_in),
    .dbg_req_in(dbg_req), .cpu_req_in(cpu_req), .rdata_out(rdata),
    .ready_out(ready), .error_out(error), .core_halted_in(core_halted_in),
    .sleep_in(sleep_in), .stop_in(stop_in), .standby_in(standby_in),
    .lp_ctl_out(lp), .tim_lo_freeze_out(lo), .tim_basic_freeze_out(bas),
    .tim_basic_out_dis_out(bas_dis), .tim_hi_freeze_out(hi),
    .tim_top_freeze_out(top), .tim_lo_moe_force_off_out(lo_moe),
    .window_dog_freeze_out(wd), .indep_dog_freeze_out(id),
    .i2c_one_timeout_freeze_out(i1), .i2c_two_timeout_freeze_out(i2),
    .trace_swo_assign_out(swo), .trace_clk_assign_out(tclk),
    .trace_data_assign_out(tdata), .trace_clk_en_out(tclk_en));
  dsu_bus_host i_host (.clk_in(clk_sys_in), .ready_in(ready),
    .error_in(error), .rdata_in(rdata), .req_out(dbg_req));
  dsu_bus_host i_cpu (.clk_in(clk_sys_in), .ready_in(ready),
    .error_in(error), .rdata_in(rdata), .req_out(cpu_req));

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic acc(input logic cpu, input logic wr, input logic [31:0] a,
      input logic [31:0] v, input logic [3:0] be, input logic raw,
      input logic exp_err);
    if (cpu) begin
      i_cpu.access(wr, a, v, be, raw, rd, rdy, er);
    end else begin
      i_host.access(wr, a, v, be, raw, rd, rdy, er);
    end
    check("ready", {31'h0, rdy}, 32'h1);
    check("error", {31'h0, er}, {31'h0, exp_err});
  endtask

  task automatic rdreg(input logic [31:0] exp);
    acc(1'b0, 1'b0, DSU_CFG_ADDR, 32'h0, 4'hf, 1'b0, 1'b0);
    check("config", rd, exp);
  endtask

  function automatic logic [23:0] frz(input logic [31:0] r, input logic h);
    logic [31:0] m;
    m = r & {32{h}};
    return {m[27:22], m[20:18], m[20:18], m[13:10], m[13:10], m[9:8],
      m[15], m[16]};
  endfunction

  function automatic logic [5:0] trc(input logic [31:0] r);
    logic [1:0] m;
    m = r[7:6];
    if (!r[5]) begin
      return 6'h0;
    end
    return {m == 2'd0, m != 2'd0, (m == 2'd0) ? 4'h0 : (m == 2'd1) ? 4'h1 :
      (m == 2'd2) ? 4'h3 : 4'hf};
  endfunction

  // Order: core, bus, source, rc keep, power, system reset, config reset.
  function automatic logic [7:0] lpx(input int mode, input logic k);
    case (mode)
      1: return {1'b1, k, DSU_SRC_SYSCLK, 4'b0100};
      2: return k ? {2'b11, DSU_SRC_RC, 4'b1101} :
        {2'b00, DSU_SRC_OFF, 4'b0101};
      default: return k ? {2'b11, DSU_SRC_RC, 4'b1111} :
        {2'b00, DSU_SRC_OFF, 4'b0011};
    endcase
  endfunction

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Whole run is under two thousand cycles; this allows ten times that.
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial begin
    {rst_b_in, por_b_in, sys_rst_b_in, core_halted_in} = 4'b0010;
    {sleep_in, stop_in, standby_in} = 3'b000;
    repeat (4) @(posedge clk_sys_in);
    #1;
    {rst_b_in, por_b_in} = 2'b11;
    rdreg(32'h0);
    check("trace", {26'h0, swo, tclk, tdata}, 32'h0);
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      core_halted_in = d[3];
      acc(d[4], 1'b1, DSU_CFG_ADDR, d, 4'hf, d[17], 1'b0);
      rdreg(d & DSU_CFG_WMASK);
      check("freeze", {8'h0, top, hi, bas, bas_dis, lo, lo_moe, wd, id, i1,
        i2}, {8'h0, frz(d, core_halted_in)});
      check("trace", {26'h0, swo, tclk, tdata}, {26'h0, trc(d)});
    end
    for (int m = 0; m < 4; m++) begin
      d = 32'h20 | (m << 6);
      acc(1'b0, 1'b1, DSU_CFG_ADDR, 32'h0, 4'hf, 1'b0, 1'b0);
      acc(1'b0, 1'b1, DSU_CFG_ADDR, d, 4'hf, 1'b0, 1'b0);
      check("trace_clk_en", {31'h0, tclk_en}, 32'h0);
      check("trace", {26'h0, swo, tclk, tdata}, {26'h0, trc(d)});
      @(posedge clk_sys_in);
      #1;
      check("trace_clk_en", {31'h0, tclk_en}, 32'h1);
    end
    for (int m = 1; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        acc(1'b0, 1'b1, DSU_CFG_ADDR, k << (m - 1), 4'hf, 1'b0, 1'b0);
        {sleep_in, stop_in, standby_in} = 3'b001 << (3 - m);
        #1;
        check("lowpower", {24'h0, lp}, {24'h0, lpx(m, k[0])});
      end
    end
    {sleep_in, stop_in, standby_in} = 3'b000;
    sys_rst_b_in = 1'b0;
    acc(1'b0, 1'b1, DSU_CFG_ADDR, 32'h307, 4'hf, 1'b0, 1'b0);
    rdreg(32'h307);
    sys_rst_b_in = 1'b1;
    acc(1'b0, 1'b1, DSU_CFG_ADDR + 32'h4, 32'h1, 4'hf, 1'b0, 1'b1);
    acc(1'b1, 1'b1, DSU_CFG_ADDR, 32'h1, 4'h3, 1'b1, 1'b1);
    rdreg(32'h307);
    // Same-cycle writes from both requesters: the debugger is kept.
    fork
      acc(1'b0, 1'b1, DSU_CFG_ADDR, 32'h0a400000, 4'hf, 1'b0, 1'b0);
      acc(1'b1, 1'b1, DSU_CFG_ADDR, 32'h05800000, 4'hf, 1'b0, 1'b0);
    join
    rdreg(32'h0a400000);
    core_halted_in = 1'b1;
    acc(1'b1, 1'b1, DSU_CFG_ADDR, DSU_CFG_WMASK, 4'hf, 1'b0, 1'b0);
    #3;
    por_b_in = 1'b0;
    #1;
    check("por_clear", {2'h0, top, hi, bas, bas_dis, lo, lo_moe, wd, id,
      i1, i2, swo, tclk, tdata}, 32'h0);
    @(posedge clk_sys_in);
    #1;
    por_b_in = 1'b1;
    rdreg(32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
